//--- hdl/dst_pkg.sv
// constants, types and the list of behaviours for the daylight-saving and time distribution block
// How it works
// - seven conversion choices, six presets plus user
// - europe: march last sunday 02->03, october back
// - britain: march last sunday 01->02, october back
// - america: april first sunday, october last back
// - australia: october last forward, march last back
// - tasmania/new zealand: october first forward, march back
// - user dates: 02:00 plus, 03:00 minus difference
// - zone difference 0 to 180 minutes
// - convert only while powered, never on backup
// - sync enabled loads module time into clock
// - send time at powerup, hourly while powered, on changes
// - sync setting resets to disabled
// - sync settable from two menu ports
// - conversion enable resets to disabled
package dst_pkg;

  // clock rate and the one-second time base
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // preset table figures
  localparam logic [4:0] HOUR_ONE       = 5'h01;
  localparam logic [4:0] HOUR_TWO       = 5'h02;
  localparam logic [4:0] HOUR_THREE     = 5'h03;
  localparam logic [3:0] MONTH_MARCH    = 4'h3;
  localparam logic [3:0] MONTH_APRIL    = 4'h4;
  localparam logic [3:0] MONTH_OCTOBER  = 4'hA;
  localparam logic [7:0] PRESET_DIFF    = 8'h3C;   // 60 minutes
  localparam logic [7:0] MAX_DIFF       = 8'hB4;   // 180 minutes
  localparam logic [9:0] MIN_PER_HOUR   = 10'h03C;
  localparam logic [4:0] WEEK_DAYS      = 5'h07;

  // reset values of the settings
  localparam logic RST_DST_EN  = 1'b0;
  localparam logic RST_SYNC_EN = 1'b0;

  // conversion choices
  typedef enum logic [2:0] {
    preset_europe      = 3'h0,
    preset_britain     = 3'h1,
    preset_america     = 3'h2,
    preset_australia   = 3'h3,
    preset_tasmania    = 3'h4,
    preset_new_zealand = 3'h5,
    preset_user        = 3'h6
  } dst_preset_t;

  // which sunday (or fixed day) a transition falls on
  typedef enum logic [1:0] {
    day_first = 2'h0,
    day_third = 2'h1,
    day_last  = 2'h2,
    day_fixed = 2'h3
  } dst_day_kind_t;

  // time of day and date; wday 0 is sunday, year 0..99
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } dst_tod_t;

  // user-defined conversion dates and difference
  typedef struct packed {
    logic [3:0] start_month;
    logic [4:0] start_day;
    logic [3:0] end_month;
    logic [4:0] end_day;
    logic [7:0] diff_min;
  } dst_user_t;

  // whole conversion setting written at once
  typedef struct packed {
    logic        enable;
    dst_preset_t preset;
    dst_user_t   user;
  } dst_cfg_t;

  // one transition description
  typedef struct packed {
    logic [3:0]    month;
    dst_day_kind_t kind;
    logic [4:0]    day;
    logic [4:0]    hour;
  } dst_edge_t;

endpackage

//--- hdl/dst_conv_sync.sv
// daylight-saving conversion, clock keeping and time-of-day distribution
module dst_conv_sync
  import dst_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES  // cycles per second
) (
  input  wire logic     i_mclk,            // controller clock
  input  wire logic     i_srst,            // synchronous reset, high
  input  wire logic     i_powered,         // mains present (low = backup)
  input  wire logic     i_cfg_wr,          // conversion setting write
  input  wire dst_cfg_t i_cfg,             // conversion setting value
  input  wire logic     i_param_sync_wr,   // sync write, parameter menu
  input  wire logic     i_param_sync_val,  // sync value, parameter menu
  input  wire logic     i_setup_sync_wr,   // sync write, setup menu
  input  wire logic     i_setup_sync_val,  // sync value, setup menu
  input  wire logic     i_set_valid,       // set clock request
  input  wire dst_tod_t i_set_tod,         // set clock value
  input  wire logic     i_sync_valid,      // time from comm module
  input  wire dst_tod_t i_sync_tod,        // comm module time value
  output dst_tod_t      o_tod,             // current time of day
  output logic          o_summer,          // summertime offset applied
  output logic          o_dst_en,          // conversion enabled
  output logic          o_sync_en,         // synchronization enabled
  output logic          o_tx_valid,        // time broadcast pulse
  output dst_tod_t      o_tx_tod           // time being broadcast
);

  // days in a month, leap years every fourth year
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
    logic [4:0] d;
    d = 5'h1F;
    case (m)
      4'h4, 4'h6, 4'h9, 4'hB: d = 5'h1E;
      4'h2:                   d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      default:                d = 5'h1F;
    endcase
    return d;
  endfunction

  // one second forward with all carries
  function automatic dst_tod_t advance(input dst_tod_t t);
    dst_tod_t n;
    n = t;
    if (t.sec != 6'h3B) begin
      n.sec = t.sec + 6'h01;
    end else begin
      n.sec = 6'h00;
      if (t.min != 6'h3B) begin
        n.min = t.min + 6'h01;
      end else begin
        n.min = 6'h00;
        if (t.hour != 5'h17) begin
          n.hour = t.hour + 5'h01;
        end else begin
          n.hour = 5'h00;
          n.wday = (t.wday == 3'h6) ? 3'h0 : t.wday + 3'h1;
          if (t.day < month_days(t.month, t.year)) begin
            n.day = t.day + 5'h01;
          end else begin
            n.day = 5'h01;
            if (t.month != 4'hC) begin
              n.month = t.month + 4'h1;
            end else begin
              n.month = 4'h1;
              n.year  = (t.year == 7'h63) ? 7'h00 : t.year + 7'h01;
            end
          end
        end
      end
    end
    return n;
  endfunction

  // move the time within the day by a number of minutes
  function automatic dst_tod_t shift(input dst_tod_t t, input logic [7:0] d, input logic fwd);
    dst_tod_t   n;
    logic [9:0] m;
    n = t;
    m = 10'(t.hour) * MIN_PER_HOUR + 10'(t.min);
    m = fwd ? m + 10'(d) : m - 10'(d);
    n.hour = 5'(m / MIN_PER_HOUR);
    n.min  = 6'(m % MIN_PER_HOUR);
    return n;
  endfunction

  // does the date fall on the transition day
  function automatic logic date_hit(input dst_edge_t e, input dst_tod_t t);
    logic hit;
    hit = 1'b0;
    if (t.month == e.month) begin
      case (e.kind)
        day_first: hit = (t.wday == 3'h0) && (t.day <= WEEK_DAYS);
        day_third: hit = (t.wday == 3'h0) && (t.day > 5'h0E) && (t.day <= 5'h15);
        day_last:  hit = (t.wday == 3'h0) && (6'(t.day) + 6'(WEEK_DAYS) > 6'(month_days(t.month, t.year)));
        default:   hit = (t.day == e.day);
      endcase
    end
    return hit;
  endfunction

  // setting and state registers
  logic [24:0] tick_cnt_ff, nxt_tick_cnt;     // second divider
  logic        tick_ff, nxt_tick;             // one-second enable
  logic        pwr_meta_ff, pwr_ff, pwr_prev_ff; // mains level synchroniser
  logic        boot_ff;                       // cleared after first broadcast
  dst_cfg_t    cfg_ff, nxt_cfg;               // conversion setting
  logic        sync_en_ff, nxt_sync_en;       // synchronization setting
  dst_tod_t    tod_ff, nxt_tod;               // clock
  logic        summer_ff, nxt_summer;         // offset currently applied
  logic        tx_ff, nxt_tx;                 // broadcast pulse
  dst_tod_t    tx_tod_ff, nxt_tx_tod;         // broadcast value

  // transition table for the chosen preset
  dst_edge_t   st_edge, end_edge;             // forward and back transitions
  logic [7:0]  diff;                          // applied difference
  dst_tod_t    t_adv;                         // time one second on

  // divider: one-cycle enable every second
  always_comb begin
    nxt_tick_cnt = tick_cnt_ff + 25'h000_0001;
    nxt_tick     = 1'b0;
    if (tick_cnt_ff == 25'(P_TICK_CYCLES - 1)) begin
      nxt_tick_cnt = 25'h000_0000;
      nxt_tick     = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tick_cnt_ff <= 25'h000_0000;
      tick_ff     <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // mains level passes two flip-flops; pwr_prev_ff finds the return of power
  // reset to the powered level, so leaving reset on mains gives no false
  // return-of-power edge and no second power-up broadcast
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pwr_meta_ff <= 1'b1;
      pwr_ff      <= 1'b1;
      pwr_prev_ff <= 1'b1;
    end else begin
      pwr_meta_ff <= i_powered;
      pwr_ff      <= pwr_meta_ff;
      pwr_prev_ff <= pwr_ff;
    end
  end

  // settings: conversion choice and synchronization switch
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_sync_en = sync_en_ff;
    if (i_cfg_wr) begin
      nxt_cfg = i_cfg;
      if (i_cfg.user.diff_min > MAX_DIFF) begin
        nxt_cfg.user.diff_min = MAX_DIFF;
      end
      if (i_cfg.preset > preset_user) begin
        nxt_cfg.preset = preset_europe;
      end
    end
    if (i_param_sync_wr) begin
      nxt_sync_en = i_param_sync_val;
    end
    if (i_setup_sync_wr) begin
      nxt_sync_en = i_setup_sync_val;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cfg_ff        <= '0;
      cfg_ff.enable <= RST_DST_EN;
      sync_en_ff    <= RST_SYNC_EN;
    end else begin
      cfg_ff     <= nxt_cfg;
      sync_en_ff <= nxt_sync_en;
    end
  end

  // preset table: forward and back dates, hours and difference
  always_comb begin
    diff     = PRESET_DIFF;
    st_edge  = '{MONTH_MARCH, day_last, 5'h00, HOUR_TWO};
    end_edge = '{MONTH_OCTOBER, day_last, 5'h00, HOUR_THREE};
    case (cfg_ff.preset)
      preset_britain: begin
        st_edge  = '{MONTH_MARCH, day_last, 5'h00, HOUR_ONE};
        end_edge = '{MONTH_OCTOBER, day_last, 5'h00, HOUR_TWO};
      end
      preset_america: begin
        st_edge  = '{MONTH_APRIL, day_first, 5'h00, HOUR_TWO};
        end_edge = '{MONTH_OCTOBER, day_last, 5'h00, HOUR_TWO};
      end
      preset_australia: begin
        st_edge  = '{MONTH_OCTOBER, day_last, 5'h00, HOUR_TWO};
        end_edge = '{MONTH_MARCH, day_last, 5'h00, HOUR_THREE};
      end
      preset_tasmania: begin
        st_edge  = '{MONTH_OCTOBER, day_first, 5'h00, HOUR_TWO};
        end_edge = '{MONTH_MARCH, day_last, 5'h00, HOUR_THREE};
      end
      preset_new_zealand: begin
        st_edge  = '{MONTH_OCTOBER, day_first, 5'h00, HOUR_TWO};
        end_edge = '{MONTH_MARCH, day_third, 5'h00, HOUR_THREE};
      end
      preset_user: begin
        st_edge  = '{cfg_ff.user.start_month, day_fixed, cfg_ff.user.start_day, HOUR_TWO};
        end_edge = '{cfg_ff.user.end_month, day_fixed, cfg_ff.user.end_day, HOUR_THREE};
        diff     = cfg_ff.user.diff_min;
      end
      default: begin
        diff = PRESET_DIFF;                          // europe figures above
      end
    endcase
  end

  // clock, conversion and broadcast
  always_comb begin
    t_adv      = advance(tod_ff);
    nxt_tod    = tod_ff;
    nxt_summer = summer_ff;
    nxt_tx     = 1'b0;
    nxt_tx_tod = tx_tod_ff;
    if (i_set_valid) begin
      nxt_tod = i_set_tod;                           // set clock changes the time
      nxt_tx  = 1'b1;
    end else if (i_sync_valid && sync_en_ff) begin
      nxt_tod = i_sync_tod;
      nxt_tx  = 1'b1;
    end else if (tick_ff) begin
      nxt_tod = t_adv;                               // clock runs on backup too
      if (pwr_ff && t_adv.min == 6'h00 && t_adv.sec == 6'h00) begin
        nxt_tx = 1'b1;                               // hourly
        // conversion only with mains present
        if (cfg_ff.enable && !summer_ff && t_adv.hour == st_edge.hour && date_hit(st_edge, t_adv)) begin
          nxt_tod    = shift(t_adv, diff, 1'b1);
          nxt_summer = 1'b1;
        end else if (cfg_ff.enable && summer_ff && t_adv.hour == end_edge.hour && date_hit(end_edge, t_adv)) begin
          nxt_tod    = shift(t_adv, diff, 1'b0);
          nxt_summer = 1'b0;                         // repeated hour cannot retrigger
        end
      end
    end
    if (!cfg_ff.enable) begin
      nxt_summer = 1'b0;
    end
    if (boot_ff || (pwr_ff && !pwr_prev_ff)) begin
      nxt_tx = 1'b1;                                 // power-up broadcast
    end
    if (nxt_tx) begin
      nxt_tx_tod = nxt_tod;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tod_ff    <= '0;
      summer_ff <= 1'b0;
      tx_ff     <= 1'b0;
      tx_tod_ff <= '0;
      boot_ff   <= 1'b1;
    end else begin
      tod_ff    <= nxt_tod;
      summer_ff <= nxt_summer;
      tx_ff     <= nxt_tx;
      tx_tod_ff <= nxt_tx_tod;
      boot_ff   <= 1'b0;
    end
  end

  // outputs straight from registers
  assign o_tod      = tod_ff;
  assign o_summer   = summer_ff;
  assign o_dst_en   = cfg_ff.enable;
  assign o_sync_en  = sync_en_ff;
  assign o_tx_valid = tx_ff;
  assign o_tx_tod   = tx_tod_ff;

endmodule

//--- test/dst_conv_sync_properties.sv
// port assertions for the conversion and time distribution block
module dst_conv_sync_checker
  import dst_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES  // kept equal to the design's
) (
  input wire logic     i_mclk,
  input wire logic     i_srst,
  input wire logic     i_powered,
  input wire logic     i_cfg_wr,
  input wire dst_cfg_t i_cfg,
  input wire logic     i_param_sync_wr,
  input wire logic     i_param_sync_val,
  input wire logic     i_setup_sync_wr,
  input wire logic     i_setup_sync_val,
  input wire logic     i_set_valid,
  input wire dst_tod_t i_set_tod,
  input wire logic     i_sync_valid,
  input wire dst_tod_t i_sync_tod,
  input wire dst_tod_t o_tod,
  input wire logic     o_summer,
  input wire logic     o_dst_en,
  input wire logic     o_sync_en,
  input wire logic     o_tx_valid,
  input wire dst_tod_t o_tx_tod
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, reset quiets every check
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_reset_defaults: assert property ($fell(i_srst) |-> !o_dst_en && !o_sync_en && !o_summer)
    else $error("settings not cleared by reset");
  a_powerup_tx: assert property ($fell(i_srst) |-> ##[1:2] o_tx_valid)
    else $error("no broadcast after power-up");
  a_set_loads: assert property (i_set_valid |=> o_tod == $past(i_set_tod) && o_tx_valid && o_tx_tod == o_tod)
    else $error("set clock not loaded and sent");
  a_sync_loads: assert property (i_sync_valid && o_sync_en && !i_set_valid |=> o_tod == $past(i_sync_tod))
    else $error("comm module time not loaded");
  a_cfg_enable: assert property (i_cfg_wr |=> o_dst_en == $past(i_cfg.enable))
    else $error("conversion enable not taken");
  a_setup_wins: assert property (i_setup_sync_wr |=> o_sync_en == $past(i_setup_sync_val))
    else $error("setup menu sync value not taken");
  a_param_sync: assert property (i_param_sync_wr && !i_setup_sync_wr |=> o_sync_en == $past(i_param_sync_val))
    else $error("parameter menu sync value not taken");
  a_summer_needs_en: assert property (!o_dst_en [*2] |-> !o_summer)
    else $error("summer offset while conversion disabled");
  a_summer_no_backup: assert property ($rose(o_summer) |-> $past(i_powered, 3))
    else $error("conversion while on backup");
  a_convert_tx: assert property ($changed(o_summer) && o_dst_en |-> o_tx_valid)
    else $error("conversion without broadcast");
  a_tx_current: assert property (o_tx_valid |-> o_tx_tod == o_tod)
    else $error("broadcast time differs from clock");

  // main scenarios reached
  c_forward: cover property ($rose(o_summer));
  c_back: cover property ($fell(o_summer) && o_tx_valid);
  c_sync: cover property (i_sync_valid && o_sync_en);
endmodule

bind dst_conv_sync dst_conv_sync_checker #(.P_TICK_CYCLES(P_TICK_CYCLES)) chk (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_powered(i_powered), .i_cfg_wr(i_cfg_wr), .i_cfg(i_cfg),
  .i_param_sync_wr(i_param_sync_wr), .i_param_sync_val(i_param_sync_val),
  .i_setup_sync_wr(i_setup_sync_wr), .i_setup_sync_val(i_setup_sync_val),
  .i_set_valid(i_set_valid), .i_set_tod(i_set_tod), .i_sync_valid(i_sync_valid), .i_sync_tod(i_sync_tod),
  .o_tod(o_tod), .o_summer(o_summer), .o_dst_en(o_dst_en), .o_sync_en(o_sync_en),
  .o_tx_valid(o_tx_valid), .o_tx_tod(o_tx_tod)
);

//--- test/dst_exp_model.sv
// expansion module that records broadcasts, plus a comm module that sends time
module dst_exp_model
  import dst_pkg::*;
(
  input  wire logic     i_mclk,        // controller clock
  input  wire logic     i_tx_valid,    // broadcast pulse
  input  wire dst_tod_t i_tx_tod,      // broadcast time
  output logic          o_sync_valid,  // comm module time pulse
  output dst_tod_t      o_sync_tod,    // comm module time value
  output int            o_count,       // broadcasts seen
  output dst_tod_t      o_last         // last broadcast time
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sync_valid = 1'b0;
    o_sync_tod   = '0;
    o_count      = 0;
    o_last       = '0;
  end
  // latch each broadcast as an expansion module would
  always @(posedge i_mclk) begin
    if (i_tx_valid === 1'b1) begin
      o_count <= o_count + 1;
      o_last  <= i_tx_tod;
    end
  end
  // one time telegram; only a suitable comm module is modelled
  task automatic send(input dst_tod_t t);
    @(posedge i_mclk);
    o_sync_valid <= 1'b1;
    o_sync_tod   <= t;
    @(posedge i_mclk);
    o_sync_valid <= 1'b0;
    o_sync_tod   <= ~t;  // released lines do not keep the old value
  endtask
endmodule

//--- test/dst_conv_sync_bench.sv
// self-checking bench for the conversion and time distribution block
module dst_conv_sync_bench
  import dst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // transition table per preset: month, day, hour of forward and back
  localparam logic [3:0] FM [7] = '{4'h3, 4'h3, 4'h4, 4'hA, 4'hA, 4'hA, 4'h3};
  localparam logic [4:0] FD [7] = '{5'h1F, 5'h1F, 5'h07, 5'h1B, 5'h06, 5'h06, 5'h1F};
  localparam logic [4:0] FH [7] = '{5'h02, 5'h01, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02};
  localparam logic [3:0] BM [7] = '{4'hA, 4'hA, 4'hA, 4'h3, 4'h3, 4'h3, 4'hB};
  localparam logic [4:0] BD [7] = '{5'h1B, 5'h1B, 5'h1B, 5'h1F, 5'h1F, 5'h11, 5'h01};
  localparam logic [4:0] BH [7] = '{5'h03, 5'h02, 5'h02, 5'h03, 5'h03, 5'h03, 5'h03};
  logic     i_mclk = 1'b0, i_srst = 1'b1, i_powered = 1'b1, i_cfg_wr = 1'b0, i_set_valid = 1'b0;
  logic     i_param_sync_wr = 1'b0, i_param_sync_val = 1'b0, i_setup_sync_wr = 1'b0, i_setup_sync_val = 1'b0;
  dst_cfg_t i_cfg = '0;
  dst_tod_t i_set_tod = '0, i_sync_tod, o_tod, o_tx_tod, last;
  logic     i_sync_valid, o_summer, o_dst_en, o_sync_en, o_tx_valid;
  int       err_total = 0, compares = 0, cnt;

  dst_conv_sync #(.P_TICK_CYCLES(4)) uut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_powered(i_powered), .i_cfg_wr(i_cfg_wr), .i_cfg(i_cfg),
    .i_param_sync_wr(i_param_sync_wr), .i_param_sync_val(i_param_sync_val),
    .i_setup_sync_wr(i_setup_sync_wr), .i_setup_sync_val(i_setup_sync_val),
    .i_set_valid(i_set_valid), .i_set_tod(i_set_tod), .i_sync_valid(i_sync_valid), .i_sync_tod(i_sync_tod),
    .o_tod(o_tod), .o_summer(o_summer), .o_dst_en(o_dst_en), .o_sync_en(o_sync_en),
    .o_tx_valid(o_tx_valid), .o_tx_tod(o_tx_tod)
  );
  dst_exp_model exp (.i_mclk(i_mclk), .i_tx_valid(o_tx_valid), .i_tx_tod(o_tx_tod),
    .o_sync_valid(i_sync_valid), .o_sync_tod(i_sync_tod), .o_count(cnt), .o_last(last));

  // 50 ns clock
  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  // compare one value and count it
  task automatic check(input string what, input logic [63:0] exp_v, input logic [63:0] got);
    compares++;
    if (got !== exp_v) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp_v, got);
    end
  endtask
  // a date in the year 24, a sunday, at hour:min:59
  function automatic dst_tod_t mk(input logic [3:0] m, input logic [4:0] d, input logic [4:0] h, input logic [5:0] mi);
    return {7'h18, m, d, 3'h0, h, mi, 6'h3B};
  endfunction
  // write the conversion setting; user dates 31 march and 1 november
  task automatic cfg(input logic en, input int p, input logic [7:0] dif);
    @(posedge i_mclk);
    i_cfg_wr <= 1'b1;
    i_cfg    <= {en, dst_preset_t'(p), 4'h3, 5'h1F, 4'hB, 5'h01, dif};
    @(posedge i_mclk);
    i_cfg_wr <= 1'b0;
    #1;
  endtask
  // both sync menus at once: param wr, val, setup wr, val
  task automatic menu(input logic [3:0] v);
    @(posedge i_mclk);
    {i_param_sync_wr, i_param_sync_val, i_setup_sync_wr, i_setup_sync_val} <= v;
    @(posedge i_mclk);
    {i_param_sync_wr, i_param_sync_val, i_setup_sync_wr, i_setup_sync_val} <= 4'h0;
    #1;
  endtask
  // set the clock, let one second pass, then one more cycle for the broadcast
  task automatic step(input dst_tod_t t);
    int n;
    @(posedge i_mclk);
    i_set_valid <= 1'b1;
    i_set_tod   <= t;
    @(posedge i_mclk);
    i_set_valid <= 1'b0;
    #1;
    for (n = 0; n < 20 && o_tod === t; n++) begin
      @(posedge i_mclk);
      #1;
    end
    @(posedge i_mclk);
    #1;
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    int p;
    int n;
    logic [4:0] dh;
    fork
      begin
        #(50 * 3000);
        err_total++;
        conclude();
      end
    join_none
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (8) @(posedge i_mclk);
    #1;
    check("dst_en", 1'b0, o_dst_en);
    check("sync_en", 1'b0, o_sync_en);
    check("powerup tx", 1, cnt);
    // every choice forward, back, then the repeated hour must not convert again
    for (p = 0; p < 7; p++) begin
      dh = (p == 6) ? 5'h03 : 5'h01;
      cfg(1'b1, p, 8'hFF);                        // (above 180 is clamped to 180)
      step(mk(FM[p], FD[p], FH[p] - 5'h01, 6'h3B));
      check("fwd hour", FH[p] + dh, o_tod.hour);
      check("fwd min", 6'h00, o_tod.min);
      check("fwd summer", 1'b1, o_summer);
      check("fwd tx", o_tod, last);
      step(mk(BM[p], BD[p], BH[p] - 5'h01, 6'h3B));
      check("back hour", BH[p] - dh, o_tod.hour);
      check("back summer", 1'b0, o_summer);
      step(mk(BM[p], BD[p], BH[p] - 5'h01, 6'h3B));
      check("again hour", BH[p], o_tod.hour);
    end
    // not the last sunday of march; the unused choice code falls back to europe
    cfg(1'b1, 7, 8'h3C);
    step(mk(4'h3, 5'h18, 5'h01, 6'h3B));
    check("wrong day", 5'h02, o_tod.hour);
    step(mk(4'h3, 5'h1F, 5'h01, 6'h3B));
    check("code7 fwd", 5'h03, o_tod.hour);
    // mains lost: clock runs, no conversion, no hourly broadcast
    @(posedge i_mclk);
    i_powered <= 1'b0;
    repeat (4) @(posedge i_mclk);
    step(mk(4'h3, 5'h1F, 5'h01, 6'h3B));
    check("backup hour", 5'h02, o_tod.hour);
    check("backup tx", mk(4'h3, 5'h1F, 5'h01, 6'h3B), last);
    n = cnt;
    @(posedge i_mclk);
    i_powered <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
    check("mains tx", n + 1, cnt);
    // conversion disabled
    cfg(1'b0, 0, 8'h3C);
    step(mk(4'h3, 5'h1F, 5'h01, 6'h3B));
    check("off hour", 5'h02, o_tod.hour);
    check("off summer", 1'b0, o_summer);
    // hourly broadcast on an ordinary date
    step(mk(4'h5, 5'h05, 5'h04, 6'h3B));
    check("hourly tx", o_tod, last);
    // comm module time ignored, then loaded once sync is on
    step(mk(4'h6, 5'h06, 5'h04, 6'h10));
    exp.send(mk(4'h6, 5'h06, 5'h09, 6'h10));
    #1;
    check("sync off", 5'h04, o_tod.hour);
    menu(4'hC);
    check("param on", 1'b1, o_sync_en);
    exp.send(mk(4'h6, 5'h06, 5'h09, 6'h10));
    #1;
    check("sync on", 5'h09, o_tod.hour);
    menu(4'hE);
    check("setup wins", 1'b0, o_sync_en);
    conclude();
  end
endmodule
